/* File: dv/core_model.sv */
// processor-core model issuing loads and stores to the data-space block
`timescale 1ns/100ps
`default_nettype none
module core_model
  import data_space_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_done,
  input wire logic i_stall,
  input wire logic [7:0] i_rdata,
  output var logic o_req,
  output var logic o_write,
  output var data_space_pkg::addr_mode_t o_mode,
  output var data_space_pkg::ptr_sel_t o_ptr,
  output var logic [15:0] o_addr,
  output var logic [5:0] o_disp,
  output var logic [7:0] o_wdata
);
  // idle request lines at time zero
  initial begin
    o_req = 1'b0;
    o_write = 1'b0;
    o_mode = MODE_DIRECT;
    o_ptr = PTR_X;
    o_addr = 16'h0000;
    o_disp = 6'h00;
    o_wdata = 8'h00;
  end
  // one access: returns data, cycles to done and stall length after it
  task automatic access(input logic wr, input addr_mode_t m, input ptr_sel_t p,
      input logic [15:0] a, input logic [5:0] d, input logic [7:0] wd,
      output logic [7:0] rd, output int lat, output int stl);
    lat = 0;
    stl = 0;
    @(posedge i_clock);
    #1;
    // a stalled core may not issue anything
    while (i_stall !== 1'b0 && stl < 100) begin
      @(posedge i_clock);
      #1;
      stl++;
    end
    o_req = 1'b1;
    o_write = wr;
    o_mode = m;
    o_ptr = p;
    o_addr = a;
    o_disp = d;
    o_wdata = wd;
    @(posedge i_clock);
    #1;
    // a held request would be taken twice, so drop it after the take
    o_req = 1'b0;
    o_addr = ~a;
    o_disp = ~d;
    o_wdata = ~wd;
    do begin
      @(negedge i_clock);
      lat++;
    end while (i_done !== 1'b1 && lat < 20);
    rd = i_rdata;
    stl = 0;
    while (i_stall === 1'b1 && stl < 50) begin
      stl++;
      @(negedge i_clock);
    end
  endtask
  // direct store, reports the stall it caused
  task automatic st(input logic [15:0] a, input logic [7:0] v, output int stl);
    logic [7:0] rd;
    int lat;
    access(1'b1, MODE_DIRECT, PTR_X, a, 6'h00, v, rd, lat, stl);
  endtask
  // direct load
  task automatic ld(input logic [15:0] a, output logic [7:0] rd, output int lat);
    int stl;
    access(1'b0, MODE_DIRECT, PTR_X, a, 6'h00, 8'h00, rd, lat, stl);
  endtask
  // software write sequence: pointer first, then arm, then strobe in the window
  task automatic ee_write(input logic [8:0] pt, input logic [7:0] v, output int stl);
    st(16'h003F, {7'h00, pt[8]}, stl);
    st(16'h003E, pt[7:0], stl);
    st(16'h003D, v, stl);
    st(16'h003C, 8'h04, stl);
    st(16'h003C, 8'h02, stl);
  endtask
endmodule // core_model
`default_nettype wire

/* File: dv/data_space_eeprom_test.sv */
// self-checking testbench for the data-space decoder and eeprom path
`timescale 1ns/100ps
`default_nettype none
module data_space_eeprom_test;
  import data_space_pkg::*;
  localparam int unsigned WCYC = 40; // shortened self-timed write
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ip_step = 1'b0;
  logic ip_load = 1'b0;
  logic [11:0] ip_value = 12'h000;
  wire logic req, wr, done, stall;
  wire addr_mode_t mode;
  wire ptr_sel_t psel;
  wire logic [15:0] addr;
  wire logic [5:0] disp;
  wire logic [7:0] wdata, rdata;
  wire logic [11:0] ip;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #20 clock = ~clock;
  data_space_eeprom #(.WRITE_CYCLES(WCYC)) dut (.i_clock(clock), .i_rstn(rstn),
    .i_req(req), .i_write(wr), .i_mode(mode), .i_ptr(psel), .i_direct_addr(addr),
    .i_disp(disp), .i_wdata(wdata), .i_ip_step(ip_step), .i_ip_load(ip_load),
    .i_ip_value(ip_value), .o_rdata(rdata), .o_done(done), .o_stall(stall),
    .o_instruction_pointer(ip));
  core_model core (.i_clock(clock), .i_done(done), .i_stall(stall), .i_rdata(rdata),
    .o_req(req), .o_write(wr), .o_mode(mode), .o_ptr(psel), .o_addr(addr),
    .o_disp(disp), .o_wdata(wdata));
  // value compare, four-state exact
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // cycle-count compare
  task automatic chk_count(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // outputs in reset, then reserved pointer bits
  task automatic t_reset();
    logic [7:0] rd;
    int lat;
    chk_val("rdata in reset", 16'h0000, 16'(rdata));
    chk_val("stall in reset", 16'h0000, 16'(stall));
    chk_val("ip in reset", 16'h0000, 16'(ip));
    @(posedge clock);
    #1 rstn = 1'b1;
    core.ld(16'h003F, rd, lat);
    chk_val("pointer high reserved", 16'h0000, 16'(rd & 8'hFE));
  endtask
  // load wins, then a step wraps the 12-bit pointer
  task automatic t_ip();
    @(posedge clock);
    #1 ip_load = 1'b1;
    ip_value = 12'hFFF;
    ip_step = 1'b1;
    @(posedge clock);
    #1 ip_load = 1'b0;
    chk_val("ip loaded", 16'h0FFF, 16'(ip));
    @(posedge clock);
    #1 ip_step = 1'b0;
    chk_val("ip wrap", 16'h0000, 16'(ip));
  endtask
  // region edges by direct address; the last one is unmapped
  task automatic t_map();
    logic [15:0] al [5] = '{16'h0000, 16'h001F, 16'h0060, 16'h045F, 16'h0460};
    logic [7:0] rd;
    int lat, s;
    foreach (al[i]) begin
      core.st(al[i], 8'h11 + 8'(i), s);
      core.ld(al[i], rd, lat);
      chk_val("map readback", (i == 4) ? 16'h0000 : 16'h0011 + 16'(i), 16'(rd));
      chk_count("access cycles", 2, lat);
    end
  endtask
  // pointer registers seen at i/o index plus 0x20
  task automatic t_ptr();
    logic [7:0] rd;
    int lat, s;
    core.st(16'h003F, 8'hFF, s);
    core.ld(16'h003F, rd, lat);
    chk_val("pointer high", 16'h0001, 16'(rd));
    core.st(16'h003E, 8'hA7, s);
    core.ld(16'h003E, rd, lat);
    chk_val("pointer low", 16'h00A7, 16'(rd));
  endtask
  // every addressing mode: displacement and pre-decrement through Y, indirect through X, post-increment through Z
  task automatic t_modes();
    logic [7:0] rd;
    int lat, s;
    core.st(16'h001C, 8'h00, s);
    core.st(16'h001D, 8'h01, s);
    core.access(1'b1, MODE_DISP, PTR_Y, 16'h0000, 6'h3F, 8'hD1, rd, lat, s);
    core.ld(16'h013F, rd, lat);
    chk_val("disp store", 16'h00D1, 16'(rd));
    core.access(1'b1, MODE_PREDEC, PTR_Y, 16'h0000, 6'h00, 8'hD2, rd, lat, s);
    core.ld(16'h00FF, rd, lat);
    chk_val("predec store", 16'h00D2, 16'(rd));
    core.ld(16'h001C, rd, lat);
    chk_val("Y low after predec", 16'h00FF, 16'(rd));
    core.st(16'h001A, 8'hFF, s);
    core.st(16'h001B, 8'h00, s);
    core.access(1'b0, MODE_INDIRECT, PTR_X, 16'h0000, 6'h00, 8'h00, rd, lat, s);
    chk_val("indirect load", 16'h00D2, 16'(rd));
    core.st(16'h001E, 8'h3F, s);
    core.st(16'h001F, 8'h01, s);
    core.access(1'b0, MODE_POSTINC, PTR_Z, 16'h0000, 6'h00, 8'h00, rd, lat, s);
    chk_val("postinc load", 16'h00D1, 16'(rd));
    core.ld(16'h001E, rd, lat);
    chk_val("Z low after postinc", 16'h0040, 16'(rd));
  endtask
  // write to the top byte, refusals while busy, then read it back
  task automatic t_write();
    logic [7:0] rd;
    int lat, s, n;
    core.ee_write(9'h1FF, 8'hA5, s);
    chk_count("write stall", 2, s);
    core.ld(16'h003C, rd, lat);
    chk_val("busy flag", 16'h0002, 16'(rd & 8'h02));
    core.st(16'h003E, 8'h00, s);
    core.ld(16'h003E, rd, lat);
    chk_val("pointer held while busy", 16'h00FF, 16'(rd));
    core.st(16'h003C, 8'h01, s);
    chk_count("read refused stall", 0, s);
    n = 0;
    do begin
      core.ld(16'h003C, rd, lat);
      n++;
    end while (rd[1] !== 1'b0 && n < 40);
    chk_val("busy cleared", 16'h0000, 16'(rd & 8'h02));
    core.st(16'h003D, 8'h00, s);
    core.st(16'h003C, 8'h01, s);
    chk_count("read stall", 4, s);
    core.ld(16'h003D, rd, lat);
    chk_val("byte 511", 16'h00A5, 16'(rd));
  endtask
  // strobes without a live arm must not write
  task automatic t_arm();
    logic [7:0] rd;
    int lat, s;
    core.st(16'h003D, 8'h3C, s);
    core.st(16'h003C, 8'h02, s);
    chk_count("unarmed strobe stall", 0, s);
    core.st(16'h003C, 8'h04, s);
    repeat (6) @(posedge clock);
    core.st(16'h003C, 8'h02, s);
    chk_count("expired arm stall", 0, s);
    core.st(16'h003C, 8'h06, s);
    chk_count("arm with strobe stall", 0, s);
    core.st(16'h003C, 8'h01, s);
    core.ld(16'h003D, rd, lat);
    chk_val("byte unchanged", 16'h00A5, 16'(rd));
  endtask
  // counts, verdict, end of run
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    t_reset();
    t_ip();
    t_map();
    t_ptr();
    t_modes();
    t_write();
    t_arm();
    end_of_test();
  end
endmodule // data_space_eeprom_test
`default_nettype wire

/* File: src/data_space_eeprom.sv */
// data-space decoder, register file, sram and eeprom access path
//
// Functional notes
// - bottom 96 to registers, next 1024 sram
// - registers 0x00-0x1F, i/o at n+0x20
// - direct mode reaches whole data space
// - displacement mode adds 0..63 to Y/Z
// - X/Y/Z in R26-R31; pre-dec, post-inc
// - sram access completes in two cycles
// - 512 eeprom bytes, linear 0 to 511
// - eeprom read stalls core four cycles
// - eeprom write stalls core two cycles
// - nine-bit pointer, high bits read zero
// - pointer not reset; software loads it first
// - eeprom registers live in i/o space
// - self-timed write with readable busy status
// - writes need arming sequence first
// - 12-bit instruction pointer, 4k words
// - arm expires after four; unarmed strobe ignored
// - write strobe clears when write finishes
// - read strobe loads buffer at once
// - busy write refuses reads and pointer writes
`timescale 1ns/100ps
`default_nettype none
module data_space_eeprom
  import data_space_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = data_space_pkg::EE_WRITE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic i_write,
  input wire data_space_pkg::addr_mode_t i_mode,
  input wire data_space_pkg::ptr_sel_t i_ptr,
  input wire logic [15:0] i_direct_addr,
  input wire logic [5:0] i_disp,
  input wire logic [7:0] i_wdata,
  input wire logic i_ip_step,
  input wire logic i_ip_load,
  input wire logic [11:0] i_ip_value,
  output logic [7:0] o_rdata,
  output logic o_done,
  output logic o_stall,
  output logic [11:0] o_instruction_pointer
);
  import data_space_pkg::*;

  localparam int unsigned WCW = $clog2(WRITE_CYCLES + 1); // write counter width
  localparam logic [WCW-1:0] WRITE_LAST = WCW'(WRITE_CYCLES - 1);

  logic [7:0] regs [REG_COUNT];   // working register file
  logic [7:0] sram [SRAM_BYTES];  // internal data sram
  logic [7:0] eeprom [EE_BYTES];  // nonvolatile byte store
  state_t state_q;                // access sequencer
  logic [15:0] addr_q;            // latched effective address
  logic wr_q;                     // latched direction
  logic [7:0] wdata_q;            // latched store data
  logic [7:0] rdata_q;
  logic done_q;
  logic stall_q;
  logic [2:0] stall_left_q;       // stall cycles still owed
  logic [11:0] ip_q;
  logic [EE_PTR_W-1:0] ptr_q;     // eeprom byte pointer, no reset
  logic [7:0] ebuf_q;             // eeprom byte buffer
  logic rdyie_q;                  // ready interrupt enable, stored only
  logic arm_q;                    // write arm
  logic [2:0] arm_left_q;
  logic busy_q;                   // write strobe bit, high while writing
  logic [WCW-1:0] wleft_q;
  logic [EE_PTR_W-1:0] waddr_q;   // snapshot of pointer at launch
  logic [7:0] wbyte_q;            // snapshot of buffer at launch
  logic [4:0] ptr_idx;
  logic [15:0] ptr_val;
  logic [15:0] ea;
  logic take;
  logic access;
  logic is_reg, is_io, is_sram;
  logic [5:0] io_off;
  logic [9:0] sram_idx;
  logic [7:0] rd_val;
  logic ctrl_wr, arm_load, rd_launch, wr_launch;

  // pointer pair lookup; X, Y, Z sit in the top six working registers
  always_comb begin
    unique case (i_ptr)
      PTR_X: ptr_idx = X_LOW;
      PTR_Y: ptr_idx = Y_LOW;
      PTR_Z: ptr_idx = Z_LOW;
      default: ptr_idx = Z_LOW; // illegal select falls back to Z
    endcase
  end
  assign ptr_val = {regs[ptr_idx + 5'h01], regs[ptr_idx]};

  // effective address per addressing mode
  always_comb begin
    unique case (i_mode)
      MODE_DIRECT: ea = i_direct_addr;
      MODE_DISP: ea = ptr_val + {10'h000, i_disp};
      MODE_PREDEC: ea = ptr_val - 16'h0001;
      default: ea = ptr_val; // plain indirect and post-increment
    endcase
  end

  // a request is only taken when idle and the core is not held
  assign take = i_req && (state_q == ST_IDLE) && !stall_q;
  assign access = (state_q == ST_ACCESS);

  // region decode of the latched address
  assign is_reg = (addr_q < IO_BASE);
  assign is_io = (addr_q >= IO_BASE) && (addr_q < SRAM_BASE);
  assign is_sram = (addr_q >= SRAM_BASE) && (addr_q <= SRAM_LAST);
  assign io_off = 6'(addr_q - IO_BASE);
  assign sram_idx = 10'(addr_q - SRAM_BASE);

  // eeprom register side effects, all from one data-space store
  assign ctrl_wr = access && wr_q && is_io && (io_off == IO_EE_CTRL);
  assign arm_load = ctrl_wr && wdata_q[CTRL_ARM];
  // strobe counts only if arm was set by an earlier store
  assign wr_launch = ctrl_wr && wdata_q[CTRL_WRITE] && arm_q && !busy_q;
  assign rd_launch = ctrl_wr && wdata_q[CTRL_READ] && !busy_q;

  // read mux; unmapped i/o and addresses past the sram read zero
  always_comb begin
    rd_val = 8'h00;
    if (is_reg) begin
      rd_val = regs[addr_q[4:0]];
    end else if (is_sram) begin
      rd_val = sram[sram_idx];
    end else if (is_io) begin
      unique case (io_off)
        IO_EE_CTRL: rd_val = {4'h0, rdyie_q, arm_q, busy_q, 1'b0};
        IO_EE_BUF: rd_val = ebuf_q;
        IO_EE_LOW: rd_val = ptr_q[7:0];
        IO_EE_HIGH: rd_val = {7'h00, ptr_q[8]};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // two-cycle sequencer: latch address, then perform the access
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      addr_q <= 16'h0000;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
    end else if (take) begin
      state_q <= ST_ACCESS;
      addr_q <= ea;
      wr_q <= i_write;
      wdata_q <= i_wdata;
    end else begin
      state_q <= ST_IDLE;
    end
  end

  // answer to the core, registered at the second edge
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= access;
      if (access && !wr_q) begin
        rdata_q <= rd_val;
      end
    end
  end

  // register file: pointer update at take, store at access edge
  // pointer update and store never share an edge, so no clash
  always_ff @(posedge i_clock) begin
    if (take && (i_mode == MODE_PREDEC)) begin
      {regs[ptr_idx + 5'h01], regs[ptr_idx]} <= ptr_val - 16'h0001;
    end else if (take && (i_mode == MODE_POSTINC)) begin
      {regs[ptr_idx + 5'h01], regs[ptr_idx]} <= ptr_val + 16'h0001;
    end
    if (access && wr_q && is_reg) begin
      regs[addr_q[4:0]] <= wdata_q;
    end
  end

  // internal sram stores
  always_ff @(posedge i_clock) begin
    if (access && wr_q && is_sram) begin
      sram[sram_idx] <= wdata_q;
    end
  end

  // eeprom byte pointer: deliberately left without reset
  always_ff @(posedge i_clock) begin
    if (access && wr_q && is_io && !busy_q) begin
      if (io_off == IO_EE_LOW) begin
        ptr_q[7:0] <= wdata_q;
      end
      if (io_off == IO_EE_HIGH) begin
        ptr_q[8] <= wdata_q[0];
      end
    end
  end

  // byte buffer: software store, or a read launch fills it at once
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ebuf_q <= 8'h00;
    end else if (rd_launch) begin
      ebuf_q <= eeprom[ptr_q];
    end else if (access && wr_q && is_io && (io_off == IO_EE_BUF)) begin
      ebuf_q <= wdata_q;
    end
  end

  // ready interrupt enable is only stored here
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rdyie_q <= 1'b0;
    end else if (ctrl_wr) begin
      rdyie_q <= wdata_q[CTRL_RDYIE];
    end
  end

  // arm window: high for four cycles after the arming store
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      arm_q <= 1'b0;
      arm_left_q <= 3'h0;
    end else if (arm_load) begin
      arm_q <= 1'b1;
      arm_left_q <= ARM_CYCLES - 3'h1;
    end else if (arm_q) begin
      if (arm_left_q == 3'h0) begin
        arm_q <= 1'b0;
      end else begin
        arm_left_q <= arm_left_q - 3'h1;
      end
    end
  end

  // self-timed write; the cell is updated only at the end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      wleft_q <= '0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
    end else if (wr_launch) begin
      busy_q <= 1'b1;
      wleft_q <= WRITE_LAST;
      waddr_q <= ptr_q;
      wbyte_q <= ebuf_q;
    end else if (busy_q) begin
      if (wleft_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        wleft_q <= wleft_q - WCW'(1);
      end
    end
  end

  // eeprom array, written once the write time has elapsed
  always_ff @(posedge i_clock) begin
    if (busy_q && (wleft_q == '0)) begin
      eeprom[waddr_q] <= wbyte_q;
    end
  end

  // stall request; a read launch outranks a write launch
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      stall_q <= 1'b0;
      stall_left_q <= 3'h0;
    end else if (rd_launch) begin
      stall_q <= 1'b1;
      stall_left_q <= READ_STALL - 3'h1;
    end else if (wr_launch) begin
      stall_q <= 1'b1;
      stall_left_q <= WRITE_STALL - 3'h1;
    end else if (stall_q) begin
      if (stall_left_q == 3'h0) begin
        stall_q <= 1'b0;
      end else begin
        stall_left_q <= stall_left_q - 3'h1;
      end
    end
  end

  // instruction pointer, frozen while the core is stalled
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ip_q <= 12'h000;
    end else if (!stall_q) begin
      if (i_ip_load) begin
        ip_q <= i_ip_value;
      end else if (i_ip_step) begin
        ip_q <= ip_q + 12'h001; // wraps inside 4k words
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_done = done_q;
  assign o_stall = stall_q;
  assign o_instruction_pointer = ip_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  access_timing_a: assert property (take |-> ##1 !done_q ##1 done_q)
    else $error("access did not answer on the second edge");
  read_stall_a: assert property (rd_launch |=> stall_q[*4] ##1 !stall_q)
    else $error("read stall is not four cycles");
  write_stall_a: assert property (wr_launch && !rd_launch |=> stall_q[*2] ##1 !stall_q)
    else $error("write stall is not two cycles");
  // a re-arm inside the window restarts it, so the expiry check needs four quiet cycles
  arm_window_a: assert property (arm_load |=> arm_q[*4])
    else $error("arm window is shorter than four cycles");
  arm_expire_a: assert property (arm_load ##1 (!arm_load)[*4] |=> !arm_q)
    else $error("arm window outlived four cycles");
  unarmed_ignore_a: assert property (ctrl_wr && !arm_q && !busy_q |=> !busy_q)
    else $error("unarmed strobe started a write");
  strobe_clear_a: assert property (busy_q && wleft_q == '0 |=> !busy_q)
    else $error("write strobe not cleared at end of write");
  busy_pointer_a: assert property (busy_q |=> ptr_q == $past(ptr_q))
    else $error("pointer changed during a write");
  busy_read_a: assert property (busy_q && ctrl_wr |=> ebuf_q == $past(ebuf_q))
    else $error("read accepted during a write");
  read_value_a: assert property (rd_launch |=> ebuf_q == eeprom[$past(ptr_q)])
    else $error("buffer not loaded from addressed byte");
  high_zero_a: assert property (access && !wr_q && is_io && io_off == IO_EE_HIGH
    |=> rdata_q[7:1] == 7'h00)
    else $error("reserved pointer bits read nonzero");
  predec_ptr_a: assert property (take && i_mode == MODE_PREDEC
    |=> addr_q == {regs[$past(ptr_idx) + 5'h01], regs[$past(ptr_idx)]})
    else $error("pre-decrement pointer not written back");

  // stall stands four cycles after the launch, so it is low on the fifth
  read_launch_c: cover property (rd_launch ##5 !stall_q);
  write_done_c: cover property (busy_q && wleft_q == '0 ##1 !busy_q);
  sram_store_c: cover property (access && wr_q && is_sram);
  disp_access_c: cover property (take && i_mode == MODE_DISP);
endmodule // data_space_eeprom
`default_nettype wire

/* File: src/data_space_pkg.sv */
// constants and types for the data-space decoder and eeprom access path
package data_space_pkg;
  // data space layout
  localparam logic [15:0] IO_BASE = 16'h0020;   // first i/o register
  localparam logic [15:0] SRAM_BASE = 16'h0060; // first internal sram byte
  localparam logic [15:0] SRAM_LAST = 16'h045F; // last mapped data address
  localparam int unsigned REG_COUNT = 32;       // working registers
  localparam int unsigned SRAM_BYTES = 1024;    // internal sram size
  // pointer pair low-byte register numbers
  localparam logic [4:0] X_LOW = 5'h1A;
  localparam logic [4:0] Y_LOW = 5'h1C;
  localparam logic [4:0] Z_LOW = 5'h1E;
  // eeprom register i/o indices (data address = index + IO_BASE)
  localparam logic [5:0] IO_EE_CTRL = 6'h1C;
  localparam logic [5:0] IO_EE_BUF = 6'h1D;
  localparam logic [5:0] IO_EE_LOW = 6'h1E;
  localparam logic [5:0] IO_EE_HIGH = 6'h1F;
  // control register bit positions
  localparam int unsigned CTRL_READ = 0;
  localparam int unsigned CTRL_WRITE = 1;
  localparam int unsigned CTRL_ARM = 2;
  localparam int unsigned CTRL_RDYIE = 3;
  // eeprom geometry
  localparam int unsigned EE_BYTES = 512;
  localparam int unsigned EE_PTR_W = 9;
  localparam int unsigned IP_W = 12;            // 4k program words
  // timing
  localparam int unsigned CLOCK_MHZ = 25;
  localparam int unsigned EE_WRITE_US = 8500;   // self-timed write
  localparam int unsigned EE_WRITE_CYCLES = EE_WRITE_US * CLOCK_MHZ;
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  // addressing modes of a load or store
  typedef enum logic [2:0] {
    MODE_DIRECT, MODE_INDIRECT, MODE_DISP, MODE_PREDEC, MODE_POSTINC
  } addr_mode_t;
  // pointer pair select
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_t;
  // access sequencer
  typedef enum logic {ST_IDLE, ST_ACCESS} state_t;
endpackage
